// file: design/bridge_config_header_upper.sv
// Upper configuration header registers and the forwarding decisions they steer.
`timescale 1ns/100ps
module bridge_config_header_upper
    import bridge_cfg_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_BE,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire txn_s I_PRI_TXN,
    input wire txn_s I_SEC_TXN,
    input wire logic [31:0] I_IO_BASE,
    input wire logic [31:0] I_IO_LIMIT,
    input wire logic I_SEC_PARITY_ERR,
    input wire logic I_DOWNSTREAM_SYSTEM_ERROR_IN_N,
    input wire logic I_MASTER_ABORT,
    input wire logic I_TARGET_ABORT_POSSIBLE,
    input wire logic I_PRI_SERR_ENABLE,
    output resp_s O_RESP,
    output logic O_UPSTREAM_SYSTEM_ERROR_OUT_N,
    output logic O_IRQ
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        cfg_s cfg;
        logic [31:0] rdata;
        resp_s resp;
        logic serr_n;
        logic [NUM_EVT-1:0] evt_status;
        logic [NUM_EVT-1:0] evt_enable;
        logic irq;
    } state_s;

    state_s r;
    state_s next_r;

    function automatic logic [31:0] io_upper_word(input cfg_s c);
        io_upper_word = {c.io_window_top_upper_half, c.io_window_bottom_upper_half};
    endfunction

    function automatic logic [31:0] ctrl_word(input cfg_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[7:0] = c.irq_routing_byte;
        w[15:8] = IRQ_PIN_VALUE;
        w[BIT_PARITY_RESP] = c.parity_resp;
        w[BIT_SERR_FWD] = c.serr_fwd;
        w[BIT_ISA] = c.isa_en;
        w[BIT_VGA] = c.vga_en;
        w[BIT_MABORT_MODE] = c.mabort_mode;
        ctrl_word = w; // Bit 20 stays zero.
    endfunction

    // Legacy VGA ranges: memory A0000h-BFFFFh, I/O 3B0h-3BBh and 3C0h-3DFh.
    function automatic logic is_vga(input txn_s t);
        logic hit;
        hit = 1'b0;
        if (t.is_mem && t.addr >= 32'h000a_0000 && t.addr <= 32'h000b_ffff)
        begin
            hit = 1'b1;
        end
        if (t.is_io && t.addr[31:16] == 16'h0000)
        begin
            if ((t.addr[9:0] >= 10'h3b0 && t.addr[9:0] <= 10'h3bb) ||
                (t.addr[9:0] >= 10'h3c0 && t.addr[9:0] <= 10'h3df))
            begin
                hit = 1'b1;
            end
        end
        is_vga = hit;
    endfunction

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    logic in_window_pri;
    logic in_window_sec;
    logic isa_alias_pri;
    logic isa_alias_sec;
    logic [NUM_EVT-1:0] evt_set;
    logic [NUM_EVT-1:0] evt_clr;
    logic [31:0] base_full;
    logic [31:0] limit_full;

    always_comb
    begin
        next_r = r;
        // The window uses the upper halves held here with the low halves given in.
        base_full = {r.cfg.io_window_bottom_upper_half, I_IO_BASE[15:0]};
        limit_full = {r.cfg.io_window_top_upper_half, I_IO_LIMIT[15:0]};
        in_window_pri = I_PRI_TXN.is_io && I_PRI_TXN.addr >= base_full &&
                        I_PRI_TXN.addr <= limit_full;
        in_window_sec = I_SEC_TXN.is_io && I_SEC_TXN.addr >= base_full &&
                        I_SEC_TXN.addr <= limit_full;
        isa_alias_pri = I_PRI_TXN.addr[31:16] == ISA_SPACE_TOP &&
                        I_PRI_TXN.addr[9:8] != ISA_LOW_QUARTER;
        isa_alias_sec = I_SEC_TXN.addr[31:16] == ISA_SPACE_TOP &&
                        I_SEC_TXN.addr[9:8] != ISA_LOW_QUARTER;
        evt_set = '0;
        evt_clr = '0;

        // Register reads answer in the next cycle only.
        next_r.rdata = 32'h0000_0000;
        if (I_RD)
        begin
            case (I_ADDR)
                OFS_IO_UPPER: next_r.rdata = io_upper_word(r.cfg);
                OFS_CAP_PTR: next_r.rdata = {24'h000000, CAP_PTR_VALUE};
                OFS_IRQ_CTRL: next_r.rdata = ctrl_word(r.cfg);
                OFS_EVT_STATUS: next_r.rdata = {29'h0, r.evt_status};
                OFS_EVT_ENABLE: next_r.rdata = {29'h0, r.evt_enable};
                default: next_r.rdata = RD_UNMAPPED;
            endcase
        end

        // Writes touch writable fields of enabled bytes only.
        if (I_WR)
        begin
            case (I_ADDR)
                OFS_IO_UPPER:
                begin
                    if (I_BE[0]) next_r.cfg.io_window_bottom_upper_half[7:0] = I_WDATA[7:0];
                    if (I_BE[1]) next_r.cfg.io_window_bottom_upper_half[15:8] = I_WDATA[15:8];
                    if (I_BE[2]) next_r.cfg.io_window_top_upper_half[7:0] = I_WDATA[23:16];
                    if (I_BE[3]) next_r.cfg.io_window_top_upper_half[15:8] = I_WDATA[31:24];
                end
                OFS_IRQ_CTRL:
                begin
                    if (I_BE[0]) next_r.cfg.irq_routing_byte = I_WDATA[7:0];
                    if (I_BE[2])
                    begin
                        next_r.cfg.parity_resp = I_WDATA[BIT_PARITY_RESP];
                        next_r.cfg.serr_fwd = I_WDATA[BIT_SERR_FWD];
                        next_r.cfg.isa_en = I_WDATA[BIT_ISA];
                        next_r.cfg.vga_en = I_WDATA[BIT_VGA];
                        next_r.cfg.mabort_mode = I_WDATA[BIT_MABORT_MODE];
                    end
                end
                OFS_EVT_CLEAR: if (I_BE[0]) evt_clr = I_WDATA[NUM_EVT-1:0];
                OFS_EVT_ENABLE: if (I_BE[0]) next_r.evt_enable = I_WDATA[NUM_EVT-1:0];
                default: next_r.cfg = r.cfg;
            endcase
        end

        // Forwarding decisions.
        next_r.resp.fwd_down = in_window_pri && !(r.cfg.isa_en && isa_alias_pri);
        if (is_vga(I_PRI_TXN))
        begin
            next_r.resp.fwd_down = r.cfg.vga_en;
        end
        // Outside the window goes upstream; ISA aliases also go up when enabled.
        next_r.resp.fwd_up = I_SEC_TXN.is_io &&
                             (!in_window_sec || (r.cfg.isa_en && isa_alias_sec));

        next_r.resp.parity_err = I_SEC_PARITY_ERR && r.cfg.parity_resp;

        // Master abort handling.
        next_r.resp.target_abort = 1'b0;
        next_r.resp.abort_data = 32'h0000_0000;
        next_r.resp.abort_done = I_MASTER_ABORT;
        next_r.serr_n = 1'b1;
        if (I_MASTER_ABORT)
        begin
            if (!r.cfg.mabort_mode)
            begin
                // Reads see all ones; write data is dropped.
                next_r.resp.abort_data = ABORT_READ_DATA;
            end
            else if (I_TARGET_ABORT_POSSIBLE)
            begin
                next_r.resp.target_abort = 1'b1;
            end
            else if (I_PRI_SERR_ENABLE)
            begin
                next_r.serr_n = 1'b0;
            end
        end
        if (!I_DOWNSTREAM_SYSTEM_ERROR_IN_N && r.cfg.serr_fwd && I_PRI_SERR_ENABLE)
        begin
            next_r.serr_n = 1'b0;
        end
        next_r.resp.serr_out = !next_r.serr_n;

        // Sticky events; a new event beats a clear in the same cycle.
        evt_set[0] = next_r.resp.parity_err;
        evt_set[1] = !I_DOWNSTREAM_SYSTEM_ERROR_IN_N && r.cfg.serr_fwd;
        evt_set[2] = I_MASTER_ABORT;
        next_r.evt_status = (r.evt_status & ~evt_clr) | evt_set;
        next_r.irq = |(next_r.evt_status & next_r.evt_enable);
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RESETN)
        begin
            r <= '0;
            r.cfg.io_window_bottom_upper_half <= IO_UPPER_RESET;
            r.cfg.io_window_top_upper_half <= IO_UPPER_RESET;
            r.cfg.irq_routing_byte <= IRQ_LINE_RESET;
            r.serr_n <= 1'b1;
        end
        else if (I_CE)
        begin
            r <= next_r;
        end
    end

    assign O_RDATA = r.rdata;
    assign O_RESP = r.resp;
    assign O_UPSTREAM_SYSTEM_ERROR_OUT_N = r.serr_n;
    assign O_IRQ = r.irq;

endmodule

// file: shared/bridge_cfg_pkg.sv
// Package with register map, field layout and carrier types of the upper bridge header.
package bridge_cfg_pkg;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] OFS_IO_UPPER = 8'h30;
    localparam logic [7:0] OFS_CAP_PTR = 8'h34;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h3c;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h40;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h44;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h48;

    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int BIT_PARITY_RESP = 16;
    localparam int BIT_SERR_FWD = 17;
    localparam int BIT_ISA = 18;
    localparam int BIT_VGA = 19;
    localparam int BIT_MABORT_MODE = 21;
    localparam logic [7:0] CAP_PTR_VALUE = 8'h80;
    localparam logic [15:0] IO_UPPER_RESET = 16'h0000;
    localparam logic [7:0] IRQ_LINE_RESET = 8'h00;
    localparam logic [7:0] IRQ_PIN_VALUE = 8'h00;
    localparam logic [31:0] ABORT_READ_DATA = 32'hffff_ffff;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // ISA aliases: within first 64KB, offset 100h..3ffh of each 1KB block.
    localparam logic [15:0] ISA_SPACE_TOP = 16'h0000;
    localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;

    // Event bits: 0 parity error, 1 forwarded system error, 2 master abort.
    localparam int NUM_EVT = 3;

    typedef struct packed {
        logic [15:0] io_window_bottom_upper_half;
        logic [15:0] io_window_top_upper_half;
        logic [7:0] irq_routing_byte;
        logic parity_resp;
        logic serr_fwd;
        logic isa_en;
        logic vga_en;
        logic mabort_mode;
    } cfg_s;

    typedef struct packed {
        logic [31:0] addr;
        logic is_io;
        logic is_mem;
        logic is_write;
    } txn_s;

    typedef struct packed {
        logic fwd_down;
        logic fwd_up;
        logic parity_err;
        logic serr_out;
        logic target_abort;
        logic [31:0] abort_data;
        logic abort_done;
    } resp_s;

endpackage

// file: testbench/bridge_config_header_upper_properties.sv
// Port checker of the upper bridge header.
`timescale 1ns/100ps
module bridge_cfg_checker
    import bridge_cfg_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic [7:0] I_ADDR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_SEC_PARITY_ERR,
    input wire logic I_DOWNSTREAM_SYSTEM_ERROR_IN_N,
    input wire logic I_MASTER_ABORT,
    input wire resp_s O_RESP,
    input wire logic O_UPSTREAM_SYSTEM_ERROR_OUT_N
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RESETN);
    chk_cap_fixed:
    assert property (I_RD && I_ADDR == 8'h34 |=> O_RDATA == 32'h80) else $error("bad cap");
    chk_pin_reserved:
    assert property (I_RD && I_ADDR == 8'h3c |=> (O_RDATA & 32'hffd0_ff00) == 32'h0)
        else $error("bad pin");
    chk_unmapped_zero:
    assert property (I_RD && I_ADDR == 8'h38 |=> O_RDATA == 32'h0) else $error("bad hole");
    chk_rdata_idle:
    assert property (!I_RD |=> O_RDATA == 32'h0) else $error("stray rdata");
    chk_parity_cause:
    assert property (O_RESP.parity_err |-> $past(I_SEC_PARITY_ERR)) else $error("stray parity");
    chk_serr_cause:
    assert property (!O_UPSTREAM_SYSTEM_ERROR_OUT_N
        |-> $past(!I_DOWNSTREAM_SYSTEM_ERROR_IN_N || I_MASTER_ABORT)) else $error("stray serr");
    chk_abort_cause:
    assert property (O_RESP.target_abort |-> $past(I_MASTER_ABORT)) else $error("stray abort");
    chk_abort_done:
    assert property (I_MASTER_ABORT |=> O_RESP.abort_done) else $error("abort lost");
    cover property (O_RESP.target_abort);
    cover property (O_RESP.fwd_up);
    cover property (!O_UPSTREAM_SYSTEM_ERROR_OUT_N);
endmodule
bind bridge_config_header_upper bridge_cfg_checker bridge_cfg_checker_i (.I_CORE_CLK,
    .I_RESETN, .I_ADDR, .I_RD, .O_RDATA, .I_SEC_PARITY_ERR, .I_DOWNSTREAM_SYSTEM_ERROR_IN_N,
    .I_MASTER_ABORT, .O_RESP, .O_UPSTREAM_SYSTEM_ERROR_OUT_N);

// file: testbench/cfg_host_model.sv
// Host model issuing configuration cycles.
`timescale 1ns/100ps
module cfg_host_model (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic [7:0] addr = 8'h0,
    output logic [31:0] wdata = 32'h0,
    output logic [3:0] be = 4'h0,
    output logic wr = 1'b0,
    output logic rd = 1'b0
);
    // An idle cycle follows each strobe, so a strobe is never set twice in one time step.
    task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        {addr, wdata, be, wr} <= {a, d, b, 1'b1};
        @(posedge clk);
        {wdata, wr} <= {~d, 1'b0};
        @(posedge clk);
    endtask
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic firmware_init();
        cfg_write(8'h3c, 32'hff, 4'h1);
    endtask
endmodule

// file: testbench/bridge_config_header_upper_bench.sv
// Self-checking bench of the upper bridge header.
`timescale 1ns/100ps
module bridge_config_header_upper_bench
    import bridge_cfg_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] w;} row_s;
    logic clk, resetn, wr, rd, par, serr_n, mabort, ta_ok, irq, up_serr_n;
    logic ce, pri_serr_en;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, got;
    txn_s pri, sec;
    resp_s resp;
    int fails, tests_run;
    row_s rows [6] = '{
        '{8'h30, 32'h1234_5678, 4'hf, 32'h1234_5678},
        '{8'h30, 32'hffff_ffff, 4'h6, 32'h12ff_ff78},
        '{8'h34, 32'h0, 4'hf, 32'h80},
        '{8'h3c, 32'hffff_ffff, 4'hf, 32'h2f_00ff},
        '{8'h3c, 32'h0, 4'hb, 32'h2f_0000},
        '{8'h38, 32'hffff_ffff, 4'hf, 32'h0}};
    bridge_config_header_upper bridge_config_header_upper_i (.I_CORE_CLK(clk),
        .I_RESETN(resetn), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata), .I_BE(be), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_PRI_TXN(pri), .I_SEC_TXN(sec), .I_IO_BASE(32'h0),
        .I_IO_LIMIT(32'hffff), .I_SEC_PARITY_ERR(par), .I_DOWNSTREAM_SYSTEM_ERROR_IN_N(serr_n),
        .I_MASTER_ABORT(mabort), .I_TARGET_ABORT_POSSIBLE(ta_ok),
        .I_PRI_SERR_ENABLE(pri_serr_en),
        .O_RESP(resp), .O_UPSTREAM_SYSTEM_ERROR_OUT_N(up_serr_n), .O_IRQ(irq));
    cfg_host_model cfg_host_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .be(be), .wr(wr), .rd(rd));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] want);
        cfg_host_model_i.cfg_read(a, got);
        check("rdata", got, want);
    endtask
    // Programs the control byte, then offers one cycle of traffic and events.
    task automatic run(input logic [7:0] c, input txn_s p, input txn_s s, input logic [2:0] ev);
        cfg_host_model_i.cfg_write(8'h3c, {8'h0, c, 16'h0}, 4'h4);
        {pri, sec, par, serr_n, mabort} <= {p, s, ev[0], ~ev[1], ev[2]};
        @(posedge clk);
        {pri, sec, par, serr_n, mabort} <= {txn_s'(0), txn_s'(0), 3'b010};
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        {resetn, par, mabort, pri, sec} = '0;
        {serr_n, ta_ok, ce, pri_serr_en} = 4'hf;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd_check(8'h30, 32'h0);
        cfg_host_model_i.firmware_init();
        rd_check(8'h3c, 32'hff);
        foreach (rows[i])
        begin
            cfg_host_model_i.cfg_write(rows[i].a, rows[i].d, rows[i].b);
            rd_check(rows[i].a, rows[i].w);
        end
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        rd_check(8'h30, 32'h0);
        // A write offered while the clock enable is low must leave the register untouched.
        ce <= 1'b0;
        cfg_host_model_i.cfg_write(8'h30, 32'hdead_beef, 4'hf);
        ce <= 1'b1;
        rd_check(8'h30, 32'h0);
        $display("register test done");
        for (int k = 0; k < 2; k++)
        begin
            run(8'(4 * k), '{32'h100, 1'b1, 1'b0, 1'b0}, '{32'h100, 1'b1, 1'b0, 1'b0}, 3'h0);
            check("isa", 32'({resp.fwd_down, resp.fwd_up}), k ? 32'h1 : 32'h2);
            run(8'(8 * k), '{32'ha_0000, 1'b0, 1'b1, 1'b0}, '0, 3'h0);
            check("vga", 32'(resp.fwd_down), 32'(k));
            run(8'(35 * k), '0, '0, 3'h3);
            check("err", 32'({resp.parity_err, up_serr_n}), k ? 32'h2 : 32'h1);
            run(8'(35 * k), '0, '0, 3'h4);
            check("abort", k ? 32'(resp.target_abort) : resp.abort_data,
                k ? 32'h1 : ABORT_READ_DATA);
        end
        ta_ok <= 1'b0;
        run(8'h23, '0, '0, 3'h4);
        check("abort serr", 32'(up_serr_n), 32'h0);
        check("abort serr out", 32'(resp.serr_out), 32'h1);
        pri_serr_en <= 1'b0;
        run(8'h23, '0, '0, 3'h6);
        check("serr gated", 32'(up_serr_n), 32'h1);
        pri_serr_en <= 1'b1;
        $display("forwarding test done");
        cfg_host_model_i.cfg_write(OFS_EVT_CLEAR, 32'h7, 4'hf);
        run(8'h23, '0, '0, 3'h1);
        @(posedge clk);
        #1;
        check("irq masked", 32'(irq), 32'h0);
        cfg_host_model_i.cfg_write(OFS_EVT_ENABLE, 32'h1, 4'hf);
        #1;
        check("irq set", 32'(irq), 32'h1);
        rd_check(OFS_EVT_STATUS, 32'h1);
        cfg_host_model_i.cfg_write(OFS_EVT_CLEAR, 32'h1, 4'hf);
        #1;
        check("irq clear", 32'(irq), 32'h0);
        $display("irq test done");
        tally_and_finish();
    end
endmodule
